// ===== logic/fesr_consts.svh
// Constants of the flash command block: codes, field positions, offsets, counts
// Assumes inclusion by the package only; the top module uses the macros from there
`ifndef FESR_CONSTS_SVH
`define FESR_CONSTS_SVH

`define FESR_CMD_READ        8'h00
`define FESR_CMD_CACHE_PROG  8'h15
`define FESR_CMD_CACHE_READ  8'h31
`define FESR_CMD_ERASE_SETUP 8'h60
`define FESR_CMD_STATUS      8'h70
`define FESR_CMD_DSTATUS     8'h71
`define FESR_CMD_READ_ID     8'h94
`define FESR_CMD_ERASE_GO    8'hd0
`define FESR_CMD_RESET       8'hff

`define FESR_ST_FAIL   0
`define FESR_ST_D0     1
`define FESR_ST_D1     2
`define FESR_ST_RDY    5
`define FESR_ST_CRDY   6
`define FESR_ST_WP     7

`define FESR_ROW_LAST  2'h2
`define FESR_ID_LAST   3'h4
`define FESR_BLK_W     11
`define FESR_BLKS_PER_DISTRICT 1024

`define FESR_CLK_NS          40
`define FESR_RESET_BUSY_NS   1000
`define FESR_RESET_CYCLES    ((`FESR_RESET_BUSY_NS + `FESR_CLK_NS - 1) / `FESR_CLK_NS)
`define FESR_ERASE_CYCLES_RST 16'h0400

`define FESR_OFF_CONFIG  8'h00
`define FESR_OFF_VFAIL   8'h04
`define FESR_OFF_STAT    8'h08
`define FESR_OFF_BLOCKS  8'h0c

`endif

// ===== logic/fesr_pkg.sv
// Types of the flash command block
// Assumes the constants header is on the include path
package fesr_pkg;
  `include "fesr_consts.svh"

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ERASE_ADDR,
    ST_ERASE_WAIT,
    ST_ID_ADDR,
    ST_BUSY_ERASE,
    ST_BUSY_RESET
  } fesr_state_e;

  typedef enum logic [2:0] {
    OUT_NONE,
    OUT_STATUS,
    OUT_DSTATUS,
    OUT_ID,
    OUT_ARRAY
  } fesr_out_e;

  typedef logic [`FESR_BLK_W-1:0] fesr_blk_t;
endpackage : fesr_pkg

// ===== logic/fesr_sync.sv
// Two-flop synchroniser for a group of pin levels
// Assumes each bit is a level; multi-bit groups settle while the strobe is stable
`timescale 1ns/1ns
module fesr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             i_clock,
  input  wire logic             i_reset,
  input  wire logic             i_clock_enable,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync;

  always_comb
  begin
    next_stage1 = stage1;
    next_sync   = o_sync;
    if (i_clock_enable)
    begin
      next_stage1 = i_async;
      next_sync   = stage1;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      stage1 <= INIT;
      o_sync <= INIT;
    end
    else
    begin
      stage1 <= next_stage1;
      o_sync <= next_sync;
    end
  end
endmodule : fesr_sync

// ===== logic/fesr_top.sv
// Flash command block: dual-district erase, identification, status, reset
// Assumes host strobes are slow against the 25 MHz clock; APB master on the same clock
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ns
module fesr_top
  import fesr_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE  = 8'h5a, // Arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'ha5, // Arbitrary value
  parameter logic [1:0] CHIPS_FIELD = 2'h1,
  parameter logic [1:0] CELLS_FIELD = 2'h0,
  parameter logic [1:0] PAGE_FIELD  = 2'h3,
  parameter logic [1:0] BLOCK_FIELD = 2'h2,
  parameter logic       WIDE_FIELD  = 1'b0,
  parameter logic [1:0] PLANE_FIELD = 2'h2
) (
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic        i_clock_enable,
  input  wire logic        i_chip_enable_n,
  input  wire logic        i_cmd_latch,
  input  wire logic        i_addr_latch,
  input  wire logic        i_write_strobe_n,
  input  wire logic        i_read_strobe_n,
  input  wire logic        i_write_protect_n,
  input  wire logic [7:0]  i_io,
  output logic      [7:0]  o_io,
  output logic             o_io_oe_n,
  input  wire logic        i_ready_busy_line,
  output logic             o_ready_busy_line,
  output logic             o_ready_busy_line_oe_n,
  output logic             o_erase_voltage_on,
  output logic             o_array_resume,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr
);
  localparam logic [15:0] RESET_CYCLES = 16'(`FESR_RESET_CYCLES);

  // Pin side
  logic [13:0] pins;
  logic        ce_n, cle, ale, we_n, re_n, wp_n, we_prev, re_prev;
  logic [7:0]  io_s;
  logic        we_rise, re_rise, cmd_ev, adr_ev;

  // Idle levels: deselected, strobes high, unprotected, so no false edge after reset
  fesr_sync #(.WIDTH(14), .INIT(14'h2700)) u_sync (
    .i_clock        (i_clock),
    .i_reset        (i_reset),
    .i_clock_enable (i_clock_enable),
    .i_async        ({i_chip_enable_n, i_cmd_latch, i_addr_latch, i_write_strobe_n,
                      i_read_strobe_n, i_write_protect_n, i_io}),
    .o_sync         (pins)
  );
  assign {ce_n, cle, ale, we_n, re_n, wp_n, io_s} = pins;
  assign we_rise = we_n & ~we_prev & ~ce_n;
  assign re_rise = re_n & ~re_prev & ~ce_n;
  assign cmd_ev  = we_rise & cle & ~ale;
  assign adr_ev  = we_rise & ale & ~cle;

  // Command state
  fesr_state_e state, next_state;
  fesr_out_e   out_mode, next_out_mode;
  logic [15:0] timer, next_timer;
  logic [1:0]  row_idx, next_row_idx;
  logic [15:0] row_lo, next_row_lo;
  logic [2:0]  id_idx, next_id_idx;
  logic [7:0]  last_cmd, next_last_cmd;
  logic        sel0, sel1, next_sel0, next_sel1;
  fesr_blk_t   blk0, blk1, next_blk0, next_blk1;
  logic        fail0, fail1, next_fail0, next_fail1;
  logic        volt, next_volt, resume, next_resume;
  logic [7:0]  io_byte, next_io_byte;
  logic        next_we_prev, next_re_prev;
  logic        busy;
  fesr_blk_t   new_blk;

  // Software registers
  logic [15:0] erase_cycles, next_erase_cycles;
  logic [1:0]  vfail, next_vfail;
  logic [31:0] rdata, next_rdata;
  logic        slverr, next_slverr;

  // Block number from the three row address bytes (page bits 16:6)
  function automatic fesr_blk_t block_of(input logic [15:0] lo, input logic [7:0] hi);
    block_of = {hi[0], lo[15:8], lo[7:6]};
  endfunction : block_of

  function automatic logic known_offset(input logic [7:0] a);
    known_offset = (a == `FESR_OFF_CONFIG) || (a == `FESR_OFF_VFAIL) ||
                   (a == `FESR_OFF_STAT) || (a == `FESR_OFF_BLOCKS);
  endfunction : known_offset

  assign busy = (state == ST_BUSY_ERASE) || (state == ST_BUSY_RESET);
  assign new_blk = block_of(row_lo, io_s);

  always_comb
  begin
    next_state    = state;
    next_out_mode = out_mode;
    next_timer    = timer;
    next_row_idx  = row_idx;
    next_row_lo   = row_lo;
    next_id_idx   = id_idx;
    next_last_cmd = last_cmd;
    next_sel0     = sel0;
    next_sel1     = sel1;
    next_blk0     = blk0;
    next_blk1     = blk1;
    next_fail0    = fail0;
    next_fail1    = fail1;
    next_volt     = volt;
    next_resume   = 1'b0;
    next_we_prev  = we_n;
    next_re_prev  = re_n;
    next_io_byte  = 8'h00;
    if (busy)
    begin
      if (timer == 16'h0000)
      begin
        next_state = ST_IDLE;
        next_volt  = 1'b0;
        if (state == ST_BUSY_ERASE)
        begin
          next_fail0 = sel0 & vfail[0];
          next_fail1 = sel1 & vfail[1];
          next_sel0  = 1'b0;
          next_sel1  = 1'b0;
        end
      end
      else
        next_timer = timer - 16'h0001;
    end
    if (cmd_ev)
    begin
      next_last_cmd = io_s;
      case (io_s)
        `FESR_CMD_RESET:
        begin
          // Aborts erase and any half-entered sequence
          next_state    = ST_BUSY_RESET;
          next_timer    = RESET_CYCLES - 16'h0001;
          next_volt     = 1'b0;
          next_sel0     = 1'b0;
          next_sel1     = 1'b0;
          next_out_mode = OUT_NONE;
        end
        `FESR_CMD_STATUS: next_out_mode = OUT_STATUS;
        `FESR_CMD_DSTATUS: next_out_mode = OUT_DSTATUS;
        default:
        begin
          // Busy: other commands are dropped, not queued
          if (!busy)
          begin
            next_state = ST_IDLE;
            case (io_s)
              `FESR_CMD_ERASE_SETUP:
              begin
                next_state   = ST_ERASE_ADDR;
                next_row_idx = 2'h0;
                if (state != ST_ERASE_WAIT)
                begin
                  next_sel0 = 1'b0;
                  next_sel1 = 1'b0;
                end
              end
              `FESR_CMD_ERASE_GO:
              begin
                // Confirm without a setup, or under write protect, starts no erase; the state returns to ST_IDLE
                if (state == ST_ERASE_WAIT && wp_n)
                begin
                  next_state = ST_BUSY_ERASE;
                  next_timer = erase_cycles;
                  next_volt  = 1'b1;
                end
              end
              `FESR_CMD_READ_ID: next_state = ST_ID_ADDR;
              `FESR_CMD_READ:
              begin
                if (out_mode == OUT_STATUS || out_mode == OUT_DSTATUS)
                begin
                  next_out_mode = OUT_ARRAY;
                  next_resume   = 1'b1;
                end
              end
              default: next_out_mode = OUT_NONE;
            endcase
          end
        end
      endcase
    end
    else if (adr_ev && !busy)
    begin
      case (state)
        ST_ERASE_ADDR:
        begin
          next_row_idx = row_idx + 2'h1;
          next_row_lo  = {io_s, row_lo[15:8]};
          if (row_idx == `FESR_ROW_LAST)
          begin
            next_state = ST_ERASE_WAIT;
            // Block lsb picks the district; either order, one block of each district, a second of the same district replaces the first
            if (new_blk[0])
            begin
              next_sel1 = 1'b1;
              next_blk1 = new_blk;
            end
            else
            begin
              next_sel0 = 1'b1;
              next_blk0 = new_blk;
            end
          end
        end
        ST_ID_ADDR:
        begin
          next_state    = ST_IDLE;
          next_out_mode = OUT_ID;
          next_id_idx   = 3'h0;
        end
        default: next_state = state;
      endcase
    end
    if (re_rise && out_mode == OUT_ID)
      next_id_idx = (id_idx == `FESR_ID_LAST) ? 3'h0 : id_idx + 3'h1;
    case (out_mode)
      OUT_STATUS:
      begin
        // No cache operations here, so both ready bits track one flag
        next_io_byte[`FESR_ST_FAIL] = fail0 | fail1;
        next_io_byte[`FESR_ST_RDY]  = ~busy;
        next_io_byte[`FESR_ST_CRDY] = ~busy;
        next_io_byte[`FESR_ST_WP]   = wp_n;
      end
      OUT_DSTATUS:
      begin
        next_io_byte[`FESR_ST_FAIL] = fail0 | fail1;
        next_io_byte[`FESR_ST_D0]   = fail0;
        next_io_byte[`FESR_ST_D1]   = fail1;
        next_io_byte[`FESR_ST_RDY]  = ~busy;
        next_io_byte[`FESR_ST_CRDY] = ~busy;
        next_io_byte[`FESR_ST_WP]   = wp_n;
      end
      OUT_ID:
      begin
        case (next_id_idx)
          3'h0: next_io_byte = MAKER_CODE;
          3'h1: next_io_byte = DEVICE_CODE;
          3'h2: next_io_byte = {4'h9, CELLS_FIELD, CHIPS_FIELD};
          3'h3: next_io_byte = {1'b0, WIDE_FIELD, BLOCK_FIELD, 2'h1, PAGE_FIELD};
          3'h4: next_io_byte = {4'h7, PLANE_FIELD, 2'h2};
          default: next_io_byte = 8'h00;
        endcase
      end
      default: next_io_byte = 8'h00;
    endcase
  end

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      state    <= ST_IDLE;
      out_mode <= OUT_NONE;
      timer    <= 16'h0000;
      row_idx  <= 2'h0;
      row_lo   <= 16'h0000;
      id_idx   <= 3'h0;
      last_cmd <= 8'h00;
      sel0     <= 1'b0;
      sel1     <= 1'b0;
      blk0     <= '0;
      blk1     <= '0;
      fail0    <= 1'b0;
      fail1    <= 1'b0;
      volt     <= 1'b0;
      resume   <= 1'b0;
      io_byte  <= 8'h00;
      we_prev  <= 1'b1;
      re_prev  <= 1'b1;
    end
    else if (i_clock_enable)
    begin
      state    <= next_state;
      out_mode <= next_out_mode;
      timer    <= next_timer;
      row_idx  <= next_row_idx;
      row_lo   <= next_row_lo;
      id_idx   <= next_id_idx;
      last_cmd <= next_last_cmd;
      sel0     <= next_sel0;
      sel1     <= next_sel1;
      blk0     <= next_blk0;
      blk1     <= next_blk1;
      fail0    <= next_fail0;
      fail1    <= next_fail1;
      volt     <= next_volt;
      resume   <= next_resume;
      io_byte  <= next_io_byte;
      we_prev  <= next_we_prev;
      re_prev  <= next_re_prev;
    end
  end

  // Byte is redriven on every read pulse from the held mode
  assign o_io      = io_byte;
  assign o_io_oe_n = ce_n | re_n | (out_mode == OUT_NONE) | (out_mode == OUT_ARRAY);
  // Open drain: only ever pulls low, shared line sensed by others
  assign o_ready_busy_line      = 1'b0;
  assign o_ready_busy_line_oe_n = ~busy;
  assign o_erase_voltage_on     = volt;
  assign o_array_resume         = resume;

  // APB slave: read data captured in setup, zero-wait access while i_clock_enable is high
  always_comb
  begin
    next_erase_cycles = erase_cycles;
    next_vfail        = vfail;
    next_rdata        = rdata;
    next_slverr       = slverr;
    if (i_psel && !i_penable)
    begin
      next_slverr = ~known_offset(i_paddr);
      case (i_paddr)
        `FESR_OFF_CONFIG: next_rdata = {16'h0000, erase_cycles};
        `FESR_OFF_VFAIL:  next_rdata = {30'h0, vfail};
        `FESR_OFF_STAT:   next_rdata = {16'h0000, last_cmd, volt, wp_n, fail1, fail0,
                                        sel1, sel0, busy, ~busy};
        `FESR_OFF_BLOCKS: next_rdata = {5'h0, blk1, 5'h0, blk0};
        default:          next_rdata = 32'h0000_0000;
      endcase
    end
    if (i_psel && i_penable && i_pwrite)
    begin
      if (i_paddr == `FESR_OFF_CONFIG)
        next_erase_cycles = i_pwdata[15:0];
      if (i_paddr == `FESR_OFF_VFAIL)
        next_vfail = i_pwdata[1:0];
    end
  end

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      erase_cycles <= `FESR_ERASE_CYCLES_RST;
      vfail        <= 2'h0;
      rdata        <= 32'h0000_0000;
      slverr       <= 1'b0;
    end
    else if (i_clock_enable)
    begin
      erase_cycles <= next_erase_cycles;
      vfail        <= next_vfail;
      rdata        <= next_rdata;
      slverr       <= next_slverr;
    end
  end

  assign o_prdata  = (i_psel && i_penable && !i_pwrite) ? rdata : 32'h0000_0000;
  assign o_pready  = i_psel & i_penable & i_clock_enable;
  assign o_pslverr = i_psel & i_penable & slverr;
endmodule : fesr_top

// ===== tb/fesr_chk_checker.sv
// Checker of the flash command block pins
// Assumes host pins move just after rising clock edges
`timescale 1ns/1ns
module fesr_chk (
  input  wire logic       i_clock,
  input  wire logic       i_reset,
  input  wire logic       i_chip_enable_n,
  input  wire logic       i_cmd_latch,
  input  wire logic       i_write_strobe_n,
  input  wire logic       i_write_protect_n,
  input  wire logic [7:0] i_io,
  input  wire logic [7:0] o_io,
  input  wire logic       o_io_oe_n,
  input  wire logic       o_ready_busy_line_oe_n,
  input  wire logic       o_erase_voltage_on,
  input  wire logic       o_array_resume
);
  logic       ws_q;
  logic       next_ws;
  logic [7:0] last_cmd;
  logic [7:0] next_cmd;
  logic       cmd_ev;
  logic       st;
  logic       rd_st;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  assign cmd_ev = i_write_strobe_n & ~ws_q & i_cmd_latch & ~i_chip_enable_n;
  assign st     = last_cmd == 8'h70 || last_cmd == 8'h71;
  assign rd_st  = st & ~o_io_oe_n;
  always_comb
  begin
    next_ws  = i_write_strobe_n;
    next_cmd = cmd_ev ? i_io : last_cmd;
  end
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      ws_q     <= 1'b1;
      last_cmd <= 8'h00;
    end
    else
    begin
      ws_q     <= next_ws;
      last_cmd <= next_cmd;
    end
  end
  sequence s_busy8;
    !o_ready_busy_line_oe_n [*8];
  endsequence
  sequence s_ff;
    cmd_ev && i_io == 8'hff;
  endsequence
  property p_rst_busy;
    s_ff |-> ##[3:6] s_busy8 ##[10:25] o_ready_busy_line_oe_n;
  endproperty
  a_rst_busy: assert property (p_rst_busy)
    else $error("reset busy span wrong");
  property p_volt_off;
    s_ff |-> ##[1:8] !o_erase_voltage_on;
  endproperty
  a_volt_off: assert property (p_volt_off)
    else $error("erase voltage kept after reset");
  property p_volt_cause;
    $rose(o_erase_voltage_on) |-> last_cmd == 8'hd0;
  endproperty
  a_volt_cause: assert property (p_volt_cause)
    else $error("erase began without confirm");
  property p_volt_busy;
    o_erase_voltage_on |-> !o_ready_busy_line_oe_n;
  endproperty
  a_volt_busy: assert property (p_volt_busy)
    else $error("erase voltage while ready");
  property p_wp;
    rd_st |-> o_io[7] == i_write_protect_n;
  endproperty
  a_wp: assert property (p_wp)
    else $error("protect bit wrong");
  property p_rdy_pair;
    rd_st |-> o_io[5] == o_io[6];
  endproperty
  a_rdy_pair: assert property (p_rdy_pair)
    else $error("ready bits differ");
  property p_zero;
    rd_st |-> o_io[4:3] == 2'h0 && (last_cmd == 8'h71 || o_io[2:1] == 2'h0);
  endproperty
  a_zero: assert property (p_zero)
    else $error("unused status bits set");
  property p_or;
    rd_st && last_cmd == 8'h71 |-> o_io[0] == (o_io[1] | o_io[2]);
  endproperty
  a_or: assert property (p_or)
    else $error("district fail not merged");
  property p_resume;
    cmd_ev && i_io == 8'h00 && st |-> ##[2:8] o_array_resume;
  endproperty
  a_resume: assert property (p_resume)
    else $error("no resume after read command");
endmodule : fesr_chk

bind fesr_top fesr_chk fesr_chk_i (.i_clock, .i_reset, .i_chip_enable_n, .i_cmd_latch, .i_write_strobe_n,
  .i_write_protect_n, .i_io, .o_io, .o_io_oe_n, .o_ready_busy_line_oe_n, .o_erase_voltage_on, .o_array_resume);

// ===== tb/fesr_host.sv
// Host controller model driving the flash pins
// Assumes calls start just after a rising clock edge
`timescale 1ns/1ns
module fesr_host
  import fesr_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic [7:0] i_io,
  output logic            o_chip_enable_n,
  output logic            o_cmd_latch,
  output logic            o_addr_latch,
  output logic            o_write_strobe_n,
  output logic            o_read_strobe_n,
  output logic [7:0]      o_io
);
  initial
  begin
    o_chip_enable_n  = 1'b0;
    o_cmd_latch      = 1'b0;
    o_addr_latch     = 1'b0;
    o_write_strobe_n = 1'b1;
    o_read_strobe_n  = 1'b1;
    o_io             = 8'h00;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge i_clock);
  endtask : hold
  // Four clocks around each edge, the pins are synchronised
  task automatic put(input logic c, input logic [7:0] d);
    o_cmd_latch  <= c;
    o_addr_latch <= ~c;
    o_io         <= d;
    hold(4);
    o_write_strobe_n <= 1'b0;
    hold(4);
    o_write_strobe_n <= 1'b1;
    hold(4);
    o_cmd_latch  <= 1'b0;
    o_addr_latch <= 1'b0;
    o_io         <= ~d;
    hold(4);
  endtask : put
  task automatic rd(output logic [7:0] b);
    o_read_strobe_n <= 1'b0;
    hold(6);
    b = i_io;
    o_read_strobe_n <= 1'b1;
    hold(5);
  endtask : rd
  // Row bytes low first; one block per district
  task automatic sel(input fesr_blk_t blk);
    put(1'b1, 8'h60);
    put(1'b0, {blk[1:0], 6'h00});
    put(1'b0, blk[9:2]);
    put(1'b0, {7'h00, blk[10]});
  endtask : sel
endmodule : fesr_host

// ===== tb/tb_top.sv
// Bench of the flash command block: APB setup, host sequences, checks
// Assumes the host model and checker bind are compiled before it
`timescale 1ns/1ns
module tb_top;
  localparam logic [1:0] CH = 2'h2;
  localparam logic [1:0] CE = 2'h1;
  localparam logic [1:0] PG = 2'h1;
  localparam logic [1:0] BK = 2'h3;
  localparam logic       WD = 1'b1;
  localparam logic [1:0] PL = 2'h3;
  logic        i_clock = 1'b0;
  logic        i_reset, i_clock_enable, i_write_protect_n, i_psel, i_penable, i_pwrite;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata;
  logic [7:0]  i_io, o_io, host_io, b;
  logic        i_chip_enable_n, i_cmd_latch, i_addr_latch, i_write_strobe_n, i_read_strobe_n;
  logic        i_ready_busy_line, o_ready_busy_line, o_ready_busy_line_oe_n, o_io_oe_n;
  logic        o_erase_voltage_on, o_array_resume, o_pready, o_pslverr, e;
  logic [31:0] o_prdata, q;
  logic [7:0]  ids [6];
  int          errors = 0, check_count = 0, busy_cnt = 0, resume_cnt = 0, n0;
  always #20 i_clock = ~i_clock;
  assign i_io = o_io_oe_n ? host_io : o_io;
  assign i_ready_busy_line = o_ready_busy_line_oe_n | o_ready_busy_line;
  always @(posedge i_clock)
  begin
    busy_cnt   <= busy_cnt + int'(!o_ready_busy_line_oe_n);
    resume_cnt <= resume_cnt + int'(o_array_resume);
  end
  fesr_top #(.MAKER_CODE(8'h5a), .DEVICE_CODE(8'ha5), .CHIPS_FIELD(CH), .CELLS_FIELD(CE),
    .PAGE_FIELD(PG), .BLOCK_FIELD(BK), .WIDE_FIELD(WD), .PLANE_FIELD(PL)) fesr_top_i (
    .i_clock, .i_reset, .i_clock_enable, .i_chip_enable_n, .i_cmd_latch, .i_addr_latch,
    .i_write_strobe_n, .i_read_strobe_n, .i_write_protect_n, .i_io, .o_io, .o_io_oe_n,
    .i_ready_busy_line, .o_ready_busy_line, .o_ready_busy_line_oe_n, .o_erase_voltage_on,
    .o_array_resume, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
    .o_pready, .o_pslverr);
  fesr_host fesr_host_i (.i_clock, .i_io, .o_chip_enable_n(i_chip_enable_n), .o_cmd_latch(i_cmd_latch),
    .o_addr_latch(i_addr_latch), .o_write_strobe_n(i_write_strobe_n),
    .o_read_strobe_n(i_read_strobe_n), .o_io(host_io));
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    chk_word({24'h0, got}, {24'h0, exp});
  endtask : chk_byte
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    i_psel   <= 1'b1;
    i_pwrite <= w;
    i_paddr  <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    n = 0;
    @(posedge i_clock);
    while (o_pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge i_clock);
    end
    if (n == 50)
    begin
      errors++;
      $display("ERROR %0t bus answer timed out", $time);
    end
    q = o_prdata;
    e = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clock);
  endtask : apb
  task automatic erase2(input logic [10:0] x, input logic [10:0] y);
    fesr_host_i.sel(x);
    fesr_host_i.sel(y);
    fesr_host_i.put(1'b1, 8'hd0);
  endtask : erase2
  task automatic wait_ready(output logic [7:0] r);
    fesr_host_i.put(1'b1, 8'h71);
    r = 8'h00;
    repeat (40) if (r[5] !== 1'b1) fesr_host_i.rd(r);
  endtask : wait_ready
  initial
  begin
    repeat (20000) @(posedge i_clock);
    errors++;
    $display("ERROR %0t watchdog expired", $time);
    report_and_stop();
  end
  initial
  begin
    i_reset           <= 1'b1;
    i_clock_enable    <= 1'b1;
    i_write_protect_n <= 1'b1;
    i_psel            <= 1'b0;
    i_penable         <= 1'b0;
    i_pwrite          <= 1'b0;
    i_paddr           <= 8'h00;
    i_pwdata          <= 32'h0;
    ids = '{8'h5a, 8'ha5, {4'h9, CE, CH}, {1'b0, WD, BK, 2'h1, PG}, {4'h7, PL, 2'h2}, 8'h5a};
    repeat (16) @(posedge i_clock);
    i_reset <= 1'b0;
    repeat (4) @(posedge i_clock);
    apb(1'b0, 8'h00, 32'h0);
    chk_word(q, 32'h400);
    chk_word({31'h0, e}, 32'h0);
    apb(1'b1, 8'h00, 32'd40);
    apb(1'b1, 8'h04, 32'h2);
    apb(1'b0, 8'h00, 32'h0);
    chk_word(q, 32'd40);
    apb(1'b0, 8'h40, 32'h0);
    chk_word({31'h0, e}, 32'h1);
    $display("test registers done");
    fesr_host_i.put(1'b1, 8'h94);
    fesr_host_i.put(1'b0, 8'h00);
    foreach (ids[i])
    begin
      fesr_host_i.rd(b);
      chk_byte(b, ids[i]);
    end
    $display("test identification done");
    fesr_host_i.put(1'b1, 8'h70);
    repeat (2)
    begin
      fesr_host_i.rd(b);
      chk_byte(b, 8'he0);
    end
    i_write_protect_n <= 1'b0;
    fesr_host_i.hold(4);
    fesr_host_i.rd(b);
    chk_byte(b, 8'h60);
    n0 = busy_cnt;
    erase2(11'd5, 11'd2046);
    fesr_host_i.hold(20);
    chk_word(32'(busy_cnt - n0), 32'h0);
    $display("test status done");
    i_write_protect_n <= 1'b1;
    fesr_host_i.hold(4);
    n0 = busy_cnt;
    erase2(11'd5, 11'd2046);
    // Frozen cycles stretch the busy span by as many clocks
    i_clock_enable <= 1'b0;
    fesr_host_i.hold(10);
    i_clock_enable <= 1'b1;
    wait_ready(b);
    chk_word(32'(busy_cnt - n0), 32'd51);
    chk_byte(b, 8'he5);
    apb(1'b0, 8'h0c, 32'h0);
    chk_word(q, 32'h0005_07fe);
    apb(1'b0, 8'h08, 32'h0);
    chk_word(q, 32'h0000_7161);
    fesr_host_i.put(1'b1, 8'h70);
    fesr_host_i.rd(b);
    chk_byte(b, 8'he1);
    $display("test erase done");
    fesr_host_i.sel(11'd3);
    n0 = busy_cnt;
    fesr_host_i.put(1'b1, 8'hff);
    // Confirm only once ready again; the abandoned sequence must not erase
    fesr_host_i.hold(20);
    fesr_host_i.put(1'b1, 8'hd0);
    fesr_host_i.hold(30);
    chk_word(32'(busy_cnt - n0), 32'd25);
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b1, 8'h00, 32'd300);
    erase2(11'd7, 11'd8);
    chk_byte({7'h0, o_erase_voltage_on}, 8'h1);
    fesr_host_i.put(1'b1, 8'hff);
    chk_byte({7'h0, o_erase_voltage_on}, 8'h0);
    wait_ready(b);
    chk_byte(b, 8'he5);
    $display("test reset done");
    fesr_host_i.put(1'b1, 8'h70);
    n0 = resume_cnt;
    fesr_host_i.put(1'b1, 8'h00);
    chk_word(32'(resume_cnt - n0), 32'h1);
    $display("test resume done");
    report_and_stop();
  end
endmodule : tb_top
